// File: hbp_pkg.sv
package hbp_pkg;
  // =====================================================================
  // clock and timing
  localparam int CLK_PS = 4000;
  localparam int ADDR_ACC_NS = 120;
  localparam int SEL_ACC_NS = 130;
  localparam int HOLD_NS = 10;
  localparam int WAIT_STATE_NS = 60;
  localparam int BOOT_WAIT_STATES = 13;
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] ADDR_ACC_CYC = CNT_W'((ADDR_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] HOLD_CYC = CNT_W'((HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] WAIT_CYC = CNT_W'((WAIT_STATE_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] BOOT_WAIT_CYC = CNT_W'(BOOT_WAIT_STATES) * WAIT_CYC;
  // =====================================================================
  // boot select address windows
  localparam logic [23:0] BOOT_BASE = 24'h000000;
  localparam logic [23:0] BOOT_SIZE_RESET = 24'h100000;
  localparam logic [23:0] BOOT_SIZE_LANE = 24'h020000;
  localparam int BOOT_REPROG_CYC = 64;
  // =====================================================================
  // bus cycle states
  typedef enum logic [1:0] {
    HBP_IDLE,
    HBP_SETUP,
    HBP_STROBE,
    HBP_HOLD
  } hbp_state_t;
endpackage : hbp_pkg

// File: hbp_lane_map.sv
`timescale 1ns/1ps
module hbp_lane_map
  import hbp_pkg::*;
(
  input wire logic addr_lsb,
  input wire logic word,
  input wire logic lane_mode,
  input wire logic in_lane_window,
  input wire logic [15:0] wdata,
  input wire logic [15:0] bus_rdata,
  output logic upper_lane_enable_n,
  output logic [15:0] bus_wdata,
  output logic [15:0] user_rdata
);
  // =====================================================================
  // lane select: inside the window, odd byte wanted on word or odd-address byte in lane mode, on every access in boot mode
  always_comb begin
    if (lane_mode) begin
      upper_lane_enable_n = ~(in_lane_window & (word | addr_lsb));
    end else begin
      upper_lane_enable_n = ~in_lane_window;
    end
  end
  // =====================================================================
  // host d15-d8 is the even lane, host d7-d0 the device low byte
  always_comb begin
    if (word) begin
      bus_wdata = wdata;
      user_rdata = bus_rdata;
    end else if (addr_lsb) begin
      bus_wdata = {8'h00, wdata[7:0]};
      user_rdata = {8'h00, bus_rdata[7:0]};
    end else begin
      bus_wdata = {wdata[7:0], 8'h00};
      user_rdata = {8'h00, bus_rdata[15:8]};
    end
  end
endmodule : hbp_lane_map

// File: hbp_host_port.sv
`timescale 1ns/1ps
module hbp_host_port
  import hbp_pkg::*;
#(
  parameter int REPROG_CYC = BOOT_REPROG_CYC
)(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [23:0] req_addr,
  input wire logic req_write,
  input wire logic req_word,
  input wire logic req_fetch,
  input wire logic [15:0] req_wdata,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  input wire logic power_select_mode,
  input wire logic combined_space,
  output logic boot_reprog_done,
  output logic [23:0] bus_addr,
  output logic high_addr_or_power_select_pin,
  output logic upper_lane_enable_n,
  output logic program_fetch_strobe_n,
  output logic host_data_strobe_n,
  output logic bus_rw,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic data_oe
);
  // =====================================================================
  // state
  typedef struct packed {
    hbp_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [6:0] boot_cnt;
    logic lane_mode;
    logic [23:0] addr;
    logic word;
    logic wr;
    logic fetch;
    logic psel;
    logic [15:0] wdata;
    logic [15:0] dout;
    logic oe;
    logic sel_n;
    logic lane_n;
    logic pstb_n;
    logic dstb_n;
    logic rv;
    logic [15:0] rdata;
  } hbp_regs_t;

  hbp_regs_t cur_ff;
  hbp_regs_t nxt_cur;
  logic lane_n_c;
  logic [15:0] bus_wdata_c;
  logic [15:0] user_rdata_c;
  logic in_window_c;

  function automatic logic in_block(input logic [23:0] a, input logic [23:0] size);
    in_block = (a >= BOOT_BASE) && (a < BOOT_BASE + size);
  endfunction : in_block

  assign in_window_c = cur_ff.lane_mode ? in_block(cur_ff.addr, BOOT_SIZE_LANE)
                                        : in_block(cur_ff.addr, BOOT_SIZE_RESET);

  hbp_lane_map u_lane (
    .addr_lsb(cur_ff.addr[0]),
    .word(cur_ff.word),
    .lane_mode(cur_ff.lane_mode),
    .in_lane_window(in_window_c),
    .wdata(cur_ff.wdata),
    .bus_rdata(data_i),
    .upper_lane_enable_n(lane_n_c),
    .bus_wdata(bus_wdata_c),
    .user_rdata(user_rdata_c)
  );

  function automatic logic [CNT_W-1:0] strobe_len(input logic lane_mode, input logic psel);
    logic [CNT_W-1:0] n;
    n = ADDR_ACC_CYC;
    if (!lane_mode) begin
      n = n + BOOT_WAIT_CYC;
    end
    if (psel) begin
      n = n + WAIT_CYC;
    end
    strobe_len = n;
  endfunction : strobe_len

  // =====================================================================
  // next state
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.rv = 1'b0;
    if (!cur_ff.lane_mode) begin
      if (cur_ff.boot_cnt == 7'(REPROG_CYC - 1)) begin
        nxt_cur.lane_mode = 1'b1;
      end else begin
        nxt_cur.boot_cnt = cur_ff.boot_cnt + 7'h01;
      end
    end
    unique case (cur_ff.st)
      HBP_IDLE: begin
        if (req_valid) begin
          nxt_cur.addr = req_addr;
          nxt_cur.word = req_word & ~req_addr[0];
          nxt_cur.wr = req_write;
          nxt_cur.fetch = req_fetch & ~req_write;
          nxt_cur.psel = power_select_mode;
          nxt_cur.wdata = req_wdata;
          nxt_cur.st = HBP_SETUP;
        end
      end
      HBP_SETUP: begin
        nxt_cur.lane_n = lane_n_c;
        nxt_cur.sel_n = 1'b0;
        nxt_cur.dout = bus_wdata_c;
        nxt_cur.oe = cur_ff.wr;
        nxt_cur.cnt = strobe_len(cur_ff.lane_mode, cur_ff.psel) - 9'h001;
        if (cur_ff.fetch && !combined_space) begin
          nxt_cur.pstb_n = 1'b0;
        end else begin
          nxt_cur.dstb_n = 1'b0;
        end
        nxt_cur.st = HBP_STROBE;
      end
      HBP_STROBE: begin
        if (cur_ff.cnt == 9'h000) begin
          nxt_cur.pstb_n = 1'b1;
          nxt_cur.dstb_n = 1'b1;
          nxt_cur.rdata = user_rdata_c;
          nxt_cur.cnt = HOLD_CYC - 9'h001;
          nxt_cur.st = HBP_HOLD;
        end else begin
          nxt_cur.cnt = cur_ff.cnt - 9'h001;
        end
      end
      HBP_HOLD: begin
        if (cur_ff.cnt == 9'h000) begin
          nxt_cur.sel_n = 1'b1;
          nxt_cur.lane_n = 1'b1;
          nxt_cur.oe = 1'b0;
          nxt_cur.rv = 1'b1;
          nxt_cur.st = HBP_IDLE;
        end else begin
          nxt_cur.cnt = cur_ff.cnt - 9'h001;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cur_ff <= '{st: HBP_IDLE, sel_n: 1'b1, lane_n: 1'b1, pstb_n: 1'b1,
                  dstb_n: 1'b1, default: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // =====================================================================
  // outputs
  assign req_ready = (cur_ff.st == HBP_IDLE);
  assign rsp_valid = cur_ff.rv;
  assign rsp_rdata = cur_ff.rdata;
  assign boot_reprog_done = cur_ff.lane_mode;
  assign bus_addr = cur_ff.addr;
  assign high_addr_or_power_select_pin = cur_ff.psel ? cur_ff.sel_n : cur_ff.addr[19];
  assign upper_lane_enable_n = cur_ff.lane_n;
  assign program_fetch_strobe_n = cur_ff.pstb_n;
  assign host_data_strobe_n = cur_ff.dstb_n;
  assign bus_rw = ~cur_ff.wr;
  assign data_o = cur_ff.dout;
  assign data_oe = cur_ff.oe;

  // =====================================================================
  // checks
  logic [CNT_W-1:0] stb_len_ff;
  logic [CNT_W-1:0] exp_len_ff;
  always_ff @(posedge clk_sys) begin
    if (!nrst || (program_fetch_strobe_n && host_data_strobe_n)) begin
      stb_len_ff <= '0;
    end else begin
      stb_len_ff <= stb_len_ff + 9'h001;
    end
  end

  // expected strobe length latched at setup, boot mode may end mid-strobe
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      exp_len_ff <= '0;
    end else if (cur_ff.st == HBP_SETUP) begin
      exp_len_ff <= ADDR_ACC_CYC + (cur_ff.lane_mode ? 9'h000 : BOOT_WAIT_CYC)
                    + (cur_ff.psel ? WAIT_CYC : 9'h000);
    end
  end

  a_strobe_len_exact: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(program_fetch_strobe_n & host_data_strobe_n) && cur_ff.st == HBP_HOLD
    |-> stb_len_ff == exp_len_ff)
    else $error("strobe length wrong");
  a_select_covers_strobe: assert property (@(posedge clk_sys) disable iff (!nrst)
    cur_ff.psel && !(program_fetch_strobe_n && host_data_strobe_n)
    |-> !high_addr_or_power_select_pin)
    else $error("power select not held during strobe");
  a_select_hold_after: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(host_data_strobe_n) && cur_ff.psel |-> !high_addr_or_power_select_pin [*3])
    else $error("power select hold too short");
  a_one_strobe_only: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(program_fetch_strobe_n == 1'b0 && host_data_strobe_n == 1'b0))
    else $error("both strobes active");
  a_fetch_uses_pstrobe: assert property (@(posedge clk_sys) disable iff (!nrst)
    cur_ff.st == HBP_SETUP && cur_ff.fetch && !combined_space |=> !program_fetch_strobe_n)
    else $error("fetch without program strobe");
  a_even_byte_lane: assert property (@(posedge clk_sys) disable iff (!nrst)
    cur_ff.st == HBP_STROBE && cur_ff.lane_mode && !cur_ff.word && !cur_ff.addr[0]
    |-> upper_lane_enable_n)
    else $error("lane enable on even byte");
  a_boot_reprog_time: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(boot_reprog_done) |-> $past(cur_ff.boot_cnt) == 7'(REPROG_CYC - 1))
    else $error("boot select reprogram time wrong");
  a_write_drive_only: assert property (@(posedge clk_sys) disable iff (!nrst)
    data_oe |-> !bus_rw && cur_ff.st != HBP_IDLE)
    else $error("data driven outside write");
  a_odd_data_low_lines: assert property (@(posedge clk_sys) disable iff (!nrst)
    data_oe && !cur_ff.word && cur_ff.addr[0] |-> data_o[7:0] == cur_ff.wdata[7:0])
    else $error("odd byte not on low lines");
endmodule : hbp_host_port

// File: hbp_dev_model.sv
`timescale 1ns/1ps
// =====================================================================
// far-side device: program memory, sram, power gating, lane steering
module hbp_dev_model
  import hbp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic power_select_mode,
  input wire logic combined_space,
  input wire logic [23:0] bus_addr,
  input wire logic high_addr_or_power_select_pin,
  input wire logic upper_lane_enable_n,
  input wire logic program_fetch_strobe_n,
  input wire logic host_data_strobe_n,
  input wire logic bus_rw,
  input wire logic data_oe,
  input wire logic [15:0] data_o,
  output logic [15:0] data_i
);
  logic [15:0] sram_ff [0:15];
  logic [15:0] idle_ff = 16'hA55A;
  logic powered, hit, any_n, sram_en, prog_en, even_on, odd_on;
  logic [15:0] word;
  always_comb begin
    powered = !power_select_mode || !high_addr_or_power_select_pin;
    hit = bus_addr[15:8] == 8'h60;
    any_n = program_fetch_strobe_n && host_data_strobe_n;
    if (combined_space) begin
      sram_en = !any_n && hit;
      prog_en = !any_n && !hit;
    end else begin
      sram_en = !host_data_strobe_n && hit;
      prog_en = !program_fetch_strobe_n;
    end
    word = sram_en ? sram_ff[bus_addr[4:1]] : {bus_addr[8:1] ^ 8'hA5, bus_addr[8:1]};
    even_on = powered && bus_rw && (sram_en || prog_en) && !bus_addr[0];
    odd_on = powered && bus_rw && (sram_en || prog_en) && !upper_lane_enable_n;
    data_i[15:8] = even_on ? word[15:8] : idle_ff[15:8];
    data_i[7:0] = odd_on ? word[7:0] : idle_ff[7:0];
  end
  // released lines toggle every cycle
  always_ff @(posedge clk_sys) begin
    idle_ff <= ~idle_ff;
    if (powered && !bus_rw && data_oe && sram_en) begin
      if (!bus_addr[0]) sram_ff[bus_addr[4:1]][15:8] <= data_o[15:8];
      if (!upper_lane_enable_n) sram_ff[bus_addr[4:1]][7:0] <= data_o[7:0];
    end
  end
endmodule : hbp_dev_model

// File: test_mcu_bus_port_steering.sv
`timescale 1ns/1ps
// =====================================================================
// bench for the host bus port
module test_mcu_bus_port_steering;
  import hbp_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic req_word = 1'b0;
  logic req_fetch = 1'b0;
  logic power_select_mode = 1'b0;
  logic combined_space = 1'b0;
  logic [23:0] req_addr = 24'h000000;
  logic [15:0] req_wdata = 16'h0000;
  logic req_ready, rsp_valid, boot_reprog_done, sel_pin, lane_n, pfs_n, ds_n, bus_rw, data_oe;
  logic [23:0] bus_addr;
  logic [15:0] rsp_rdata, data_i, data_o, rd;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  int lat, lat0;
  always #2 clk_sys = ~clk_sys;
  hbp_host_port #(.REPROG_CYC(4)) i_hbp_host_port (.clk_sys(clk_sys), .nrst(nrst),
    .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr), .req_write(req_write),
    .req_word(req_word), .req_fetch(req_fetch), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .power_select_mode(power_select_mode),
    .combined_space(combined_space), .boot_reprog_done(boot_reprog_done), .bus_addr(bus_addr),
    .high_addr_or_power_select_pin(sel_pin), .upper_lane_enable_n(lane_n),
    .program_fetch_strobe_n(pfs_n), .host_data_strobe_n(ds_n), .bus_rw(bus_rw),
    .data_i(data_i), .data_o(data_o), .data_oe(data_oe));
  hbp_dev_model i_hbp_dev_model (.clk_sys(clk_sys), .power_select_mode(power_select_mode),
    .combined_space(combined_space), .bus_addr(bus_addr), .high_addr_or_power_select_pin(sel_pin),
    .upper_lane_enable_n(lane_n), .program_fetch_strobe_n(pfs_n), .host_data_strobe_n(ds_n),
    .bus_rw(bus_rw), .data_oe(data_oe), .data_o(data_o), .data_i(data_i));
  // =====================================================================
  // report and compare
  task summarize;
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk16
  task chk_int(input string name, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk_int
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  // =====================================================================
  // one bus cycle: request held until taken, then wait for the answer
  task access(input logic [23:0] a, input logic w, input logic wd, input logic f,
    input logic [15:0] d);
    req_addr <= a;
    req_write <= w;
    req_word <= wd;
    req_fetch <= f;
    req_wdata <= d;
    req_valid <= 1'b1;
    do @(posedge clk_sys); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    lat = 0;
    do begin
      @(posedge clk_sys);
      lat++;
    end while (rsp_valid !== 1'b1);
    rd = rsp_rdata;
  endtask : access
  // =====================================================================
  // scenarios
  task t_word;
    access(24'h006004, 1'b1, 1'b1, 1'b0, 16'h1234);
    access(24'h006004, 1'b0, 1'b1, 1'b0, 16'h0000);
    chk16("word read", 16'h1234, rd);
  endtask : t_word
  task t_bytes;
    access(24'h006007, 1'b1, 1'b0, 1'b0, 16'h00AB);
    access(24'h006006, 1'b1, 1'b0, 1'b0, 16'h00CD);
    access(24'h006006, 1'b0, 1'b1, 1'b0, 16'h0000);
    chk16("word of bytes", 16'hCDAB, rd);
    access(24'h006004, 1'b0, 1'b0, 1'b0, 16'h0000);
    chk16("even byte", 16'h0012, rd);
    access(24'h006005, 1'b0, 1'b0, 1'b0, 16'h0000);
    chk16("odd byte", 16'h0034, rd);
  endtask : t_bytes
  task t_spaces;
    access(24'h006004, 1'b0, 1'b1, 1'b1, 16'h0000);
    chk16("separate fetch", 16'hA702, rd);
    combined_space <= 1'b1;
    access(24'h006004, 1'b0, 1'b1, 1'b1, 16'h0000);
    chk16("combined overlap", 16'h1234, rd);
    access(24'h000010, 1'b0, 1'b1, 1'b1, 16'h0000);
    chk16("combined fetch", 16'hAD08, rd);
    combined_space <= 1'b0;
  endtask : t_spaces
  task t_power;
    access(24'h006004, 1'b0, 1'b1, 1'b0, 16'h0000);
    lat0 = lat;
    power_select_mode <= 1'b1;
    access(24'h006004, 1'b0, 1'b1, 1'b0, 16'h0000);
    chk16("gated read", 16'h1234, rd);
    chk_int("select wait", int'(WAIT_CYC), lat - lat0);
    chk16("select idle", 16'h0001, {15'h0000, sel_pin});
    power_select_mode <= 1'b0;
    access(24'h086004, 1'b0, 1'b0, 1'b0, 16'h0000);
    chk16("address pin", 16'h0001, {15'h0000, sel_pin});
    chk16("far even byte", 16'h0012, rd);
  endtask : t_power
  task t_boot;
    nrst <= 1'b0;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    access(24'h006004, 1'b0, 1'b1, 1'b0, 16'h0000);
    chk16("boot read", 16'h1234, rd);
    chk_int("boot wait", int'(BOOT_WAIT_CYC), lat - lat0);
    chk16("boot done", 16'h0001, {15'h0000, boot_reprog_done});
  endtask : t_boot
  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    chk16("idle pins", 16'h0007, {13'h0000, lane_n, pfs_n, ds_n});
    chk16("idle drive", 16'h0002, {14'h0000, req_ready, data_oe});
    lat = 0;
    while (boot_reprog_done !== 1'b1) begin
      @(posedge clk_sys);
      lat++;
    end
    chk_int("boot reprogram", 4, lat);
    t_word();
    t_bytes();
    t_spaces();
    t_power();
    t_boot();
    summarize();
  end
endmodule : test_mcu_bus_port_steering
